// [ahm_master_ctl.sv]
// Purpose: master side address phase control with wait state and error handling
// Assumes: one bus clock mclk, synchronous reset srst, slave on the same clock
// Notes: no data bus here; the user sees a pulse per completed or failed beat
//
// Summary of operation
// - transfer type held during waits except three permitted changes
// - idle may become nonseq in a wait, then held until ready
// - fixed burst busy may become seq in a wait, then held
// - busy only between beats of a multi-beat burst
// - undefined burst busy may become any type during waits
// - address changes at most once per wait, except idle or error
// - idle address may change freely; nonseq address held until ready
// - on error the address may change while ready is low
// - second error cycle drives idle, cancelling the pipelined access
// - protection bit 0 low for fetch, high for data
// - protection bit 1 low for user, high for privileged
// - bit 2 marks bufferable, bit 3 marks cacheable
// - unknown attributes give the fixed privileged data pattern
// - protection follows address timing, constant through a burst
// - burst code incr is the undefined length burst
`timescale 1ns/1ps
`include "ahm_regs.svh"

module ahm_master_ctl (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // user request side
    input wire logic cmd_valid,
    input wire ahm_pkg::ahm_cmd_type cmd,
    output logic cmd_ready,
    input wire logic beat_pause,
    input wire logic incr_stop,
    output logic beat_done,
    output logic beat_err,
    // bus side
    output ahm_pkg::ahm_bus_type bus,
    input wire logic hready,
    input wire logic hresp
);
    import ahm_pkg::*;

    localparam ahm_state_type ST_RESET = '{
        bus: '{haddr: `AHM_ADDR_RST, htrans: TR_IDLE, hburst: `AHM_BU_SINGLE,
               hsize: 3'h0, hwrite: 1'b0, hprot: `AHM_PROT_FALLBACK},
        left: `AHM_LEFT_ZERO, dphase: 1'b0, done: 1'b0, err: 1'b0};

    ahm_state_type st_reg;
    ahm_state_type st_next;

    // beats of a burst; an undefined burst takes its length from the user
    function automatic logic [`AHM_LEN_W-1:0] burst_beats(
        input logic [2:0] burst,
        input logic [`AHM_LEN_W-1:0] len);
        logic [`AHM_LEN_W-1:0] n;
        n = `AHM_BEATS_1;
        case (burst)
            `AHM_BU_SINGLE: n = `AHM_BEATS_1;
            `AHM_BU_INCR: n = (len == `AHM_LEFT_ZERO) ? `AHM_BEATS_1 : len;
            `AHM_BU_WRAP4, `AHM_BU_INCR4: n = `AHM_BEATS_4;
            `AHM_BU_WRAP8, `AHM_BU_INCR8: n = `AHM_BEATS_8;
            default: n = `AHM_BEATS_16;
        endcase
        return n;
    endfunction : burst_beats

    // next beat address; wrapping bursts stay inside beats times size
    function automatic logic [`AHM_AW-1:0] next_addr(input ahm_bus_type b);
        logic [`AHM_LOW_BITS-1:0] step;
        logic [`AHM_LOW_BITS-1:0] mask;
        logic [`AHM_AW-1:0] sum;
        logic wrap;
        step = `AHM_LOW_BITS'(1) << b.hsize;
        wrap = (b.hburst == `AHM_BU_WRAP4) || (b.hburst == `AHM_BU_WRAP8) ||
               (b.hburst == `AHM_BU_WRAP16);
        mask = `AHM_LOW_BITS'(burst_beats(b.hburst, `AHM_LEFT_ZERO)) * step
               - `AHM_LOW_BITS'(1);
        sum = b.haddr + `AHM_AW'(step);
        if (wrap) begin
            sum = (b.haddr & ~`AHM_AW'(mask)) | (sum & `AHM_AW'(mask));
        end
        return sum;
    endfunction : next_addr

    // protection pattern from the user attributes
    function automatic logic [3:0] prot_bits(input ahm_attr_type a);
        logic [3:0] p;
        p = `AHM_PROT_FALLBACK;
        if (a.known) begin
            p[`AHM_PROT_DATA] = a.data;
            p[`AHM_PROT_PRIV] = a.privileged;
            p[`AHM_PROT_BUF] = a.bufferable;
            p[`AHM_PROT_CACHE] = a.cacheable;
        end
        return p;
    endfunction : prot_bits

    ahm_trans_type cur;
    logic is_incr;
    logic err_first;
    logic more;
    logic end_ok;
    logic take;

    // decode of the present address phase and response
    always_comb begin
        cur = st_reg.bus.htrans;
        // relaxed busy rules only for incr
        is_incr = (st_reg.bus.hburst == `AHM_BU_INCR);
        // first error cycle has ready low
        err_first = !hready && (hresp == `AHM_RESP_ERROR);
        more = (st_reg.left != `AHM_LEFT_ZERO);
        // a burst may end early only when it has undefined length
        end_ok = is_incr && incr_stop && (cur != TR_IDLE);
    end

    // request acceptance; a taken command shows as nonseq next cycle
    always_comb begin
        if (err_first) begin
            cmd_ready = 1'b0;
        end else if (hready) begin
            cmd_ready = (cur == TR_IDLE) || (cur != TR_BUSY && !more) || end_ok;
        end else begin
            // undefined burst busy may turn into nonseq
            cmd_ready = (cur == TR_IDLE) || (cur == TR_BUSY && end_ok);
        end
        take = cmd_valid && cmd_ready;
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.err = 1'b0;
        // data phase follows an address accepted with ready high
        if (hready) begin
            st_next.dphase = (cur == TR_NONSEQ) || (cur == TR_SEQ);
            st_next.done = st_reg.dphase && (hresp != `AHM_RESP_ERROR);
            st_next.err = st_reg.dphase && (hresp == `AHM_RESP_ERROR);
        end
        if (err_first) begin
            st_next.bus.htrans = TR_IDLE;
            // address is free now; park it on the last beat address
            st_next.bus.haddr = st_reg.bus.haddr;
            st_next.left = `AHM_LEFT_ZERO;
        end else if (take) begin
            // one address change, held until ready is high
            // this is the only address change made during a wait
            st_next.bus.haddr = cmd.addr;
            st_next.bus.htrans = TR_NONSEQ;
            st_next.bus.hburst = cmd.burst;
            st_next.bus.hsize = cmd.size;
            st_next.bus.hwrite = cmd.write;
            // attributes latched at burst start only
            st_next.bus.hprot = prot_bits(cmd.attr);
            st_next.left = burst_beats(cmd.burst, cmd.len) - `AHM_ONE_BEAT;
        end else if (hready) begin
            // advance only when the slave accepts the address
            case (cur)
                TR_NONSEQ, TR_SEQ: begin
                    if (more) begin
                        st_next.bus.haddr = next_addr(st_reg.bus);
                        // busy only with beats still to come
                        if (beat_pause) begin
                            st_next.bus.htrans = TR_BUSY;
                        end else begin
                            st_next.bus.htrans = TR_SEQ;
                            st_next.left = st_reg.left - `AHM_ONE_BEAT;
                        end
                    end else begin
                        st_next.bus.htrans = TR_IDLE;
                    end
                end
                TR_BUSY: begin
                    if (end_ok) begin
                        st_next.bus.htrans = TR_IDLE;
                        st_next.left = `AHM_LEFT_ZERO;
                    end else if (!beat_pause) begin
                        st_next.bus.htrans = TR_SEQ;
                        st_next.left = st_reg.left - `AHM_ONE_BEAT;
                    end
                end
                TR_IDLE: begin
                    st_next.bus.htrans = TR_IDLE;
                end
                default: begin
                    st_next.bus.htrans = TR_IDLE;
                end
            endcase
        end else begin
            // slave is waiting; only the permitted changes below
            // anything else holds type and address
            case (cur)
                TR_BUSY: begin
                    if (end_ok) begin
                        st_next.bus.htrans = TR_IDLE;
                        st_next.left = `AHM_LEFT_ZERO;
                    end else if (!beat_pause) begin
                        // busy to seq, address already on the bus
                        st_next.bus.htrans = TR_SEQ;
                        st_next.left = st_reg.left - `AHM_ONE_BEAT;
                    end
                end
                default: begin
                    // nonseq and seq stay until ready high
                    st_next.bus.htrans = cur;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign bus = st_reg.bus;
    assign beat_done = st_reg.done;
    assign beat_err = st_reg.err;

endmodule : ahm_master_ctl

// [ahm_regs.svh]
// Purpose: named encodings and constants for the bus master transfer control
// Assumes: single bus clock, 32-bit address
// Notes: definitions only, shared by the package and the control module
`ifndef AHM_REGS_SVH
`define AHM_REGS_SVH

// transfer type codes
`define AHM_TR_IDLE 2'h0
`define AHM_TR_BUSY 2'h1
`define AHM_TR_NONSEQ 2'h2
`define AHM_TR_SEQ 2'h3

// burst type codes
`define AHM_BU_SINGLE 3'h0
`define AHM_BU_INCR 3'h1
`define AHM_BU_WRAP4 3'h2
`define AHM_BU_INCR4 3'h3
`define AHM_BU_WRAP8 3'h4
`define AHM_BU_INCR8 3'h5
`define AHM_BU_WRAP16 3'h6
`define AHM_BU_INCR16 3'h7

// beat counts of the fixed bursts
`define AHM_BEATS_1 8'h01
`define AHM_BEATS_4 8'h04
`define AHM_BEATS_8 8'h08
`define AHM_BEATS_16 8'h10

// protection bit positions and the fallback pattern
`define AHM_PROT_DATA 0
`define AHM_PROT_PRIV 1
`define AHM_PROT_BUF 2
`define AHM_PROT_CACHE 3
`define AHM_PROT_FALLBACK 4'h3

// response level on the error line
`define AHM_RESP_ERROR 1'h1

// field widths and reset values
`define AHM_AW 32
`define AHM_LEN_W 8
`define AHM_ADDR_RST 32'h0000_0000
`define AHM_LEFT_ZERO 8'h00
`define AHM_ONE_BEAT 8'h01
`define AHM_LOW_BITS 12

`endif

// [ahm_pkg.sv]
// Purpose: types shared by the transfer control and its users
// Assumes: constants come from ahm_regs.svh
// Notes: the transfer type is an enum; all other carriers are packed structs
`include "ahm_regs.svh"

package ahm_pkg;

    // transfer type on the bus
    typedef enum logic [1:0] {
        TR_IDLE = `AHM_TR_IDLE,
        TR_BUSY = `AHM_TR_BUSY,
        TR_NONSEQ = `AHM_TR_NONSEQ,
        TR_SEQ = `AHM_TR_SEQ
    } ahm_trans_type;

    // access attributes for the protection lines
    typedef struct packed {
        logic known;
        logic cacheable;
        logic bufferable;
        logic privileged;
        logic data;
    } ahm_attr_type;

    // one burst request from the user side
    typedef struct packed {
        logic [`AHM_AW-1:0] addr;
        logic write;
        logic [2:0] burst;
        logic [2:0] size;
        logic [`AHM_LEN_W-1:0] len;
        ahm_attr_type attr;
    } ahm_cmd_type;

    // address phase signals driven to the bus
    typedef struct packed {
        logic [`AHM_AW-1:0] haddr;
        ahm_trans_type htrans;
        logic [2:0] hburst;
        logic [2:0] hsize;
        logic hwrite;
        logic [3:0] hprot;
    } ahm_bus_type;

    // whole state of the control module
    typedef struct packed {
        ahm_bus_type bus;
        logic [`AHM_LEN_W-1:0] left;
        logic dphase;
        logic done;
        logic err;
    } ahm_state_type;

endpackage : ahm_pkg

// [ahm_assertions.sv]
// Purpose: protocol checks on the transfer control ports
// Assumes: one clock mclk, synchronous reset srst
// Notes: an error first cycle is hready low with hresp high
`timescale 1ns/1ps
`include "ahm_regs.svh"
module ahm_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // user side
    input wire logic cmd_valid,
    input wire ahm_pkg::ahm_cmd_type cmd,
    input wire logic cmd_ready,
    input wire logic beat_pause,
    input wire logic incr_stop,
    input wire logic beat_done,
    input wire logic beat_err,
    // bus side
    input wire ahm_pkg::ahm_bus_type bus,
    input wire logic hready,
    input wire logic hresp
);
    import ahm_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // a wait cycle with okay response, and a taken command
    sequence s_wait;
        !hready && !hresp;
    endsequence
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    // held transfer type and address while waited, busy exits in fixed bursts, no busy in single bursts
    chk_nonseq_hold: assert property (
        s_wait ##0 bus.htrans == TR_NONSEQ |=> bus.htrans == TR_NONSEQ) else $error("nonseq moved");
    chk_seq_hold: assert property (
        s_wait ##0 bus.htrans == TR_SEQ |=> bus.htrans == TR_SEQ) else $error("seq moved");
    chk_addr_hold: assert property (
        s_wait ##0 bus.htrans[1] |=> $stable(bus.haddr)) else $error("address moved");
    chk_busy_exit: assert property (
        s_wait ##0 bus.htrans == TR_BUSY && bus.hburst != `AHM_BU_INCR
        |=> bus.htrans inside {TR_BUSY, TR_SEQ}) else $error("fixed busy left");
    chk_busy_single: assert property (
        bus.htrans == TR_BUSY |-> bus.hburst != `AHM_BU_SINGLE) else $error("busy in single");
    // error handling
    chk_err_idle: assert property (
        hresp && !hready |=> bus.htrans == TR_IDLE) else $error("no idle on error");
    chk_err_report: assert property (
        hresp && hready |=> beat_err) else $error("error not reported");
    // protection lines
    chk_prot_map: assert property (
        s_take ##0 cmd.attr.known |=> bus.hprot == $past(cmd.attr[3:0])) else $error("bad hprot");
    chk_prot_fix: assert property (
        s_take ##0 !cmd.attr.known |=> bus.hprot == `AHM_PROT_FALLBACK && bus.htrans == TR_NONSEQ)
        else $error("bad fallback");
    chk_prot_burst: assert property (
        bus.htrans inside {TR_BUSY, TR_SEQ} |-> $stable(bus.hprot)) else $error("hprot moved");
endmodule : ahm_chk

bind ahm_master_ctl ahm_chk i_ahm_chk (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .beat_pause(beat_pause), .incr_stop(incr_stop),
    .beat_done(beat_done), .beat_err(beat_err), .bus(bus), .hready(hready), .hresp(hresp));

// [ahm_slave_model.sv]
// Purpose: selected slave answering with ready and response
// Assumes: waits and err_on change only between bursts
// Notes: okay during waits, error always two cycles
`timescale 1ns/1ps
module ahm_slave_model (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // bench control
    input wire logic [3:0] waits,
    input wire logic err_on,
    // bus side
    input wire ahm_pkg::ahm_bus_type bus,
    output logic hready,
    output logic hresp
);
    import ahm_pkg::*;
    logic [3:0] cnt_reg;
    logic err_reg;
    logic act;
    // only nonseq and seq open a data phase
    assign act = bus.htrans[1];
    // waits first, okay during them, then two error cycles
    always_ff @(posedge mclk) begin
        if (srst) begin
            hready <= 1'b1;
            hresp <= 1'b0;
            cnt_reg <= 4'h0;
            err_reg <= 1'b0;
        end else if (hready) begin
            cnt_reg <= act ? waits : 4'h0;
            err_reg <= act & err_on;
            hresp <= act & err_on & (waits == 4'h0);
            hready <= !(act & (err_on | (waits != 4'h0)));
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            hresp <= err_reg & (cnt_reg == 4'h1);
            hready <= !err_reg & (cnt_reg == 4'h1);
        end else begin
            hready <= 1'b1;
            hresp <= err_reg;
        end
    end
endmodule : ahm_slave_model

// [tb.sv]
// Purpose: self-checking bench for the transfer control
// Assumes: slave model answers with the waits and errors set here
// Notes: outputs are sampled on the falling edge
`timescale 1ns/1ps
`include "ahm_regs.svh"
module tb;
    import ahm_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    ahm_cmd_type cmd = '0;
    logic beat_pause = 1'b0;
    logic incr_stop = 1'b0;
    logic [3:0] waits = 4'h2;
    logic err_on = 1'b0;
    logic cmd_ready, beat_done, beat_err, hready, hresp;
    ahm_bus_type bus;
    int err_count = 0;
    int n_compared = 0;
    int nd = 0;
    int ne = 0;
    int cyc = 0;
    always #4 mclk = ~mclk;
    ahm_master_ctl i_ahm_master_ctl (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .beat_pause(beat_pause), .incr_stop(incr_stop),
        .beat_done(beat_done), .beat_err(beat_err), .bus(bus), .hready(hready), .hresp(hresp));
    ahm_slave_model i_ahm_slave_model (.mclk(mclk), .srst(srst), .waits(waits),
        .err_on(err_on), .bus(bus), .hready(hready), .hresp(hresp));
    // pulses counted where settled
    always @(negedge mclk) begin
        nd += int'(beat_done === 1'b1);
        ne += int'(beat_err === 1'b1);
    end
    // hang guard, far above the run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask : check
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // request held until ready seen high at a falling edge, then dropped at the next rising edge
    task automatic send(input logic [2:0] bu, input logic [31:0] a, input ahm_attr_type at);
        int n;
        n = 0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd <= '{a, 1'b1, bu, 3'h2, 8'h8, at};
        @(negedge mclk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        cmd_valid <= 1'b0;
        @(negedge mclk);
    endtask : send
    task automatic wait_cnt(input int d, input int e);
        int n;
        n = 0;
        while ((nd < d || ne < e) && n < 300) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_cnt
    task automatic t_prot();
        ahm_attr_type at;
        for (int i = 0; i < 5; i++) begin
            at = '{i < 4, i[0], i[1], !i[0], !i[1]};
            send(`AHM_BU_SINGLE, 32'h100 + 32'(i * 4), at);
            check("nonseq", bus.htrans, TR_NONSEQ);
            check("addr", bus.haddr, 32'h100 + 32'(i * 4));
            check("hburst", bus.hburst, `AHM_BU_SINGLE);
            check("hsize", bus.hsize, 3'h2);
            check("hwrite", bus.hwrite, 1'b1);
            check("hprot", bus.hprot, i < 4 ? {at.cacheable, at.bufferable, at.privileged, at.data} : 4'h3);
            wait_cnt(nd + 1, 0);
        end
    endtask : t_prot
    // pause released inside the first beat's waits
    task automatic t_pause(input logic [2:0] bu, input int nb);
        int d0;
        d0 = nd;
        @(posedge mclk);
        beat_pause <= 1'b1;
        send(bu, 32'h34, '0);
        repeat (2) @(posedge mclk);
        beat_pause <= 1'b0;
        @(negedge mclk);
        check("busy", bus.htrans, TR_BUSY);
        check("busy addr", bus.haddr, 32'h38);
        check("refused", cmd_ready, 1'b0);
        wait_cnt(d0 + nb, 0);
        check("beats", nd - d0, nb);
        check("last addr", bus.haddr, bu == `AHM_BU_WRAP4 ? 32'h30 : 32'h40);
    endtask : t_pause
    // undefined burst leaves busy straight for a new nonseq inside the waits
    task automatic t_swap();
        int d0;
        d0 = nd;
        @(posedge mclk);
        beat_pause <= 1'b1;
        send(`AHM_BU_INCR, 32'h60, '0);
        fork
            send(`AHM_BU_INCR4, 32'h10, '0);
            begin
                @(posedge mclk);
                incr_stop <= 1'b1;
            end
        join
        check("swap", bus.htrans, TR_NONSEQ);
        check("swap addr", bus.haddr, 32'h10);
        @(posedge mclk);
        incr_stop <= 1'b0;
        beat_pause <= 1'b0;
        wait_cnt(d0 + 5, 0);
        check("swap beats", nd - d0, 5);
    endtask : t_swap
    task automatic t_stop();
        int d0;
        d0 = nd;
        @(posedge mclk);
        beat_pause <= 1'b1;
        send(`AHM_BU_INCR, 32'h60, '0);
        repeat (2) @(posedge mclk);
        incr_stop <= 1'b1;
        repeat (6) @(posedge mclk);
        incr_stop <= 1'b0;
        beat_pause <= 1'b0;
        @(negedge mclk);
        check("idle", bus.htrans, TR_IDLE);
        check("beats", nd - d0, 1);
    endtask : t_stop
    task automatic t_error();
        int d0;
        int e0;
        d0 = nd;
        e0 = ne;
        @(posedge mclk);
        err_on <= 1'b1;
        send(`AHM_BU_INCR4, 32'h24, '0);
        wait_cnt(0, e0 + 1);
        check("err", ne - e0, 1);
        check("done", nd - d0, 0);
        check("idle", bus.htrans, TR_IDLE);
        @(posedge mclk);
        err_on <= 1'b0;
    endtask : t_error
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check("rst htrans", bus.htrans, TR_IDLE);
        check("rst hprot", bus.hprot, `AHM_PROT_FALLBACK);
        t_prot();
        t_pause(`AHM_BU_INCR4, 4);
        t_pause(`AHM_BU_WRAP4, 4);
        t_stop();
        t_swap();
        t_error();
        test_done();
    end
endmodule : tb
